// *** inc/adcsq_pkg.sv ***
// Shared constants, types and decoding for the converter sequencer.
// Assumes a single 25 MHz system clock and a Wishbone classic register bus.
package adcsq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] ADR_CONV_CTRL = 8'h00;
    localparam logic [7:0] ADR_CLK_PWR_REF = 8'h04;
    localparam logic [7:0] ADR_PIN_SELECT = 8'h08;
    localparam logic [7:0] ADR_RESULT_HIGH = 8'h0C;
    localparam logic [7:0] ADR_RESULT_LOW = 8'h10;
    localparam logic [7:0] ADR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h18;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CC_START_BIT = 7;
    localparam int CC_BUSY_BIT = 6;
    localparam int CPR_PD_BIT = 6;
    localparam int CPR_REF_BIT = 5;
    localparam int IRQ_EOC_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic START_RST = 1'b0;
    localparam logic BUSY_RST = 1'b1;
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic PD_RST = 1'b0;
    localparam logic REF_RST = 1'b0;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [5:0] PINS_RST = 6'h00;
    localparam logic [11:0] RESULT_RST = 12'h000;
    localparam logic CPR_TOP_BIT_VAL = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Divisor codes and timing
    localparam logic [2:0] DIV_CODE_1 = 3'h4;
    localparam logic [2:0] DIV_CODE_2 = 3'h0;
    localparam logic [2:0] DIV_CODE_4 = 3'h5;
    localparam logic [2:0] DIV_CODE_8 = 3'h1;
    localparam logic [2:0] DIV_CODE_16 = 3'h6;
    localparam logic [2:0] DIV_CODE_32 = 3'h2;
    localparam logic [3:0] CONV_LAST_TICK = 4'hF;
    localparam logic [9:0] CONV_PERIODS = 10'h010;

    typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_CONV} adcsq_state_e;

    // Undefined codes fall back to the slowest rate so a conversion still ends
    function automatic logic [5:0] adcsq_div_ratio(input logic [2:0] code);
        case (code)
            DIV_CODE_1: adcsq_div_ratio = 6'h01;
            DIV_CODE_2: adcsq_div_ratio = 6'h02;
            DIV_CODE_4: adcsq_div_ratio = 6'h04;
            DIV_CODE_8: adcsq_div_ratio = 6'h08;
            DIV_CODE_16: adcsq_div_ratio = 6'h10;
            default: adcsq_div_ratio = 6'h20;
        endcase
    endfunction

endpackage

// *** inc/adcsq_div_if.sv ***
// Link between the sequencer and its converter clock divider.
// Both ends run on the same system clock.
`timescale 1ns/1ps
interface adcsq_div_if;
    logic [2:0] code;
    logic restart;
    logic tick;
    modport seq (output code, output restart, input tick);
    modport div (input code, input restart, output tick);
endinterface

// *** rtl/adcsq_clkdiv.sv ***
// Converter clock divider: one tick per converter clock period.
// Assumes the sequencer holds the code steady between restarts.
`timescale 1ns/1ps
module adcsq_clkdiv
    import adcsq_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Sequencer side
    adcsq_div_if.div dif
);

    logic [5:0] cnt_reg;
    logic tick_reg;
    logic [5:0] limit;

    assign limit = adcsq_div_ratio(dif.code) - 6'h01;
    assign dif.tick = tick_reg;

    ////////////////////////////////////////////////////////////////////////
    // Restart aligns the first period to the launch
    always_ff @(posedge CLK) begin
        if (SRST || dif.restart) begin
            cnt_reg <= 6'h00;
            tick_reg <= 1'b0;
        end else if (cnt_reg >= limit) begin
            cnt_reg <= 6'h00;
            tick_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 6'h01;
            tick_reg <= 1'b0;
        end
    end

endmodule

// *** rtl/adcsq_top.sv ***
// Converter sequencer and control registers behind a Wishbone classic slave.
// Assumes an external analog core that samples on the launch pulse.
//
// Overview of operation
// - Reference select 0 uses supply, 1 uses external reference pin or regulator.
// - Clock/power/reference register bits four and three read as zero.
// - Divisor code picks divide by 1, 2, 4, 8, 16 or 32.
// - Pin select register bits seven and six read as zero.
// - Each set pin bit makes its shared pin an analog input.
// - Start pulse low-high-low; conversion begins after the return low.
// - While start stays high, converter held in reset and busy forced high.
// - Busy clears by itself when a conversion finishes.
// - End of conversion sets request flag; enabled flag raises interrupt.
// - Power-down bit 1 switches converter off; conversions only when 0.
// - Reference select 1 gives the shared pin its reference function.
// - Channel code selects six analog pins or two op-amp outputs.
// - Result left-justified: high byte bits 11..4, low nibble reads zero.
// - A conversion lasts sixteen converter clock periods.
// - Analog pin overrides port direction and disconnects its pull-high.
`timescale 1ns/1ps
module adcsq_top
    import adcsq_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Wishbone classic slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Interrupt
    output logic IRQ_O,
    // Analog core
    input wire logic [11:0] RESULT_IN,
    output logic CONV_RESET,
    output logic CONV_LAUNCH,
    output logic CONV_TICK,
    output logic CONV_POWER_DOWN,
    output logic [2:0] INPUT_CHANNEL_SELECT,
    output logic REF_SOURCE_SELECT,
    // Pin sharing
    output logic VREF_PIN_TAKEN,
    output logic [5:0] ANALOG_PIN_ENABLES,
    output logic [5:0] PULLUP_DISCONNECT
);

    adcsq_div_if dif ();

    adcsq_clkdiv u_div (
        .CLK(CLK),
        .SRST(SRST),
        .dif(dif)
    );

    logic start_reg;
    logic start_dly_reg;
    logic busy_reg;
    logic [2:0] chan_reg;
    logic pd_reg;
    logic ref_reg;
    logic [2:0] div_reg;
    logic [2:0] conv_div_reg;
    logic [5:0] pins_reg;
    logic [11:0] result_reg;
    logic eoc_stat_reg;
    logic eoc_mask_reg;
    logic irq_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic launch_reg;
    logic [3:0] tick_cnt_reg;
    adcsq_state_e state_reg;
    adcsq_state_e state_next;
    logic start_rise;
    logic start_fall;
    logic launch;
    logic done;
    logic req;
    logic wr;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign req = WB_CYC_I && WB_STB_I;
    // Writes take effect at the edge where ack is seen
    assign wr = req && WB_WE_I && ack_reg && WB_SEL_I[0];

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req && !ack_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata_reg <= 32'h00000000;
        end else if (req && !ack_reg) begin
            case (WB_ADR_I)
                ADR_CONV_CTRL: rdata_reg <= {24'h000000, start_reg, busy_reg, 3'h0, chan_reg};
                ADR_CLK_PWR_REF: rdata_reg <= {24'h000000, CPR_TOP_BIT_VAL, pd_reg, ref_reg,
                                               2'h0, div_reg};
                ADR_PIN_SELECT: rdata_reg <= {24'h000000, 2'h0, pins_reg};
                ADR_RESULT_HIGH: rdata_reg <= {24'h000000, result_reg[11:4]};
                ADR_RESULT_LOW: rdata_reg <= {24'h000000, result_reg[3:0], 4'h0};
                ADR_IRQ_STATUS: rdata_reg <= {31'h00000000, eoc_stat_reg};
                ADR_IRQ_MASK: rdata_reg <= {31'h00000000, eoc_mask_reg};
                default: rdata_reg <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            start_reg <= START_RST;
            chan_reg <= CHAN_RST;
        end else if (wr && WB_ADR_I == ADR_CONV_CTRL) begin
            start_reg <= WB_DAT_I[CC_START_BIT];
            chan_reg <= WB_DAT_I[2:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pd_reg <= PD_RST;
            ref_reg <= REF_RST;
            div_reg <= DIV_RST;
        end else if (wr && WB_ADR_I == ADR_CLK_PWR_REF) begin
            pd_reg <= WB_DAT_I[CPR_PD_BIT];
            ref_reg <= WB_DAT_I[CPR_REF_BIT];
            div_reg <= WB_DAT_I[2:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pins_reg <= PINS_RST;
        end else if (wr && WB_ADR_I == ADR_PIN_SELECT) begin
            pins_reg <= WB_DAT_I[5:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            eoc_mask_reg <= 1'b0;
        end else if (wr && WB_ADR_I == ADR_IRQ_MASK) begin
            eoc_mask_reg <= WB_DAT_I[IRQ_EOC_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start edge detection; the start bit is already in this clock domain
    assign start_rise = start_reg && !start_dly_reg;
    assign start_fall = !start_reg && start_dly_reg;
    // A pulse while powered down is dropped, the converter cannot run
    assign launch = start_fall && !pd_reg;
    assign done = state_reg == ST_CONV && dif.tick && tick_cnt_reg == CONV_LAST_TICK;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            start_dly_reg <= START_RST;
        end else begin
            start_dly_reg <= start_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_reg) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (launch) begin
                    state_next = ST_CONV;
                end else if (start_fall) begin
                    state_next = ST_IDLE;
                end
            end
            ST_CONV: begin
                if (start_reg) begin
                    state_next = ST_HOLD;
                end else if (pd_reg || done) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Divisor latched at launch so a mid-conversion write cannot skew timing
    always_ff @(posedge CLK) begin
        if (SRST) begin
            conv_div_reg <= DIV_RST;
        end else if (launch) begin
            conv_div_reg <= div_reg;
        end
    end

    assign dif.code = conv_div_reg;
    assign dif.restart = launch;

    always_ff @(posedge CLK) begin
        if (SRST || state_reg != ST_CONV) begin
            tick_cnt_reg <= 4'h0;
        end else if (dif.tick) begin
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            launch_reg <= 1'b0;
        end else begin
            launch_reg <= launch;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Busy flag and result
    always_ff @(posedge CLK) begin
        if (SRST) begin
            busy_reg <= BUSY_RST;
        end else if (start_reg) begin
            busy_reg <= 1'b1;
        end else if (done) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            result_reg <= RESULT_RST;
        end else if (done) begin
            result_reg <= RESULT_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt: a completion in the clearing cycle keeps the flag set
    always_ff @(posedge CLK) begin
        if (SRST) begin
            eoc_stat_reg <= 1'b0;
        end else if (done) begin
            eoc_stat_reg <= 1'b1;
        end else if (wr && WB_ADR_I == ADR_IRQ_STATUS && WB_DAT_I[IRQ_EOC_BIT]) begin
            eoc_stat_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= eoc_stat_reg && eoc_mask_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdata_reg;
    assign IRQ_O = irq_reg;
    assign CONV_RESET = start_reg;
    assign CONV_LAUNCH = launch_reg;
    assign CONV_TICK = dif.tick;
    assign CONV_POWER_DOWN = pd_reg;
    assign INPUT_CHANNEL_SELECT = chan_reg;
    assign REF_SOURCE_SELECT = ref_reg;
    assign VREF_PIN_TAKEN = ref_reg;
    // Direction override and pull-high removal follow the same enable
    assign ANALOG_PIN_ENABLES = pins_reg;
    assign PULLUP_DISCONNECT = pins_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    logic [9:0] conv_cyc_reg;
    always_ff @(posedge CLK) begin
        if (SRST || state_reg != ST_CONV) begin
            conv_cyc_reg <= 10'h000;
        end else begin
            conv_cyc_reg <= conv_cyc_reg + 10'h001;
        end
    end

    sequence s_start_pulse;
        start_reg ##1 !start_reg;
    endsequence

    sequence s_launch_ok;
        s_start_pulse ##0 !pd_reg;
    endsequence

    a_busy_on_start: assert property ($rose(start_reg) |=> busy_reg ##1 busy_reg)
        else $error("busy not forced by start");
    a_hold_reset: assert property (start_reg |-> CONV_RESET ##1 state_reg == ST_HOLD)
        else $error("converter not held in reset");
    a_launch_fall: assert property (s_launch_ok |=> state_reg == ST_CONV && CONV_LAUNCH)
        else $error("conversion did not launch after start pulse");
    a_conv_length: assert property (done |-> conv_cyc_reg ==
        CONV_PERIODS * {4'h0, adcsq_div_ratio(conv_div_reg)})
        else $error("conversion length wrong");
    a_busy_clear: assert property (done && !start_reg |=> !busy_reg && eoc_stat_reg)
        else $error("completion not flagged");
    a_irq_level: assert property (eoc_stat_reg && eoc_mask_reg |=> IRQ_O)
        else $error("interrupt not raised");
    a_irq_masked: assert property (!eoc_mask_reg |=> !IRQ_O)
        else $error("masked interrupt raised");
    a_pd_blocks: assert property (pd_reg && !start_reg |=> state_reg != ST_CONV)
        else $error("conversion while powered down");
    a_result_take: assert property (done |=> result_reg == $past(RESULT_IN))
        else $error("result not captured");
    a_cpr_reserved: assert property (req && !ack_reg && !WB_WE_I &&
        WB_ADR_I == ADR_CLK_PWR_REF |=> WB_DAT_O[4:3] == 2'h0 && WB_DAT_O[7])
        else $error("reserved control bits not as fixed");
    a_pin_reserved: assert property (req && !ack_reg && !WB_WE_I &&
        WB_ADR_I == ADR_PIN_SELECT |=> WB_DAT_O[7:6] == 2'h0)
        else $error("reserved pin bits not zero");

endmodule

// *** verif/adcsq_core_model.sv ***
// Behavioural model of the analog converter core.
// Assumes the sequencer pulses launch once and ticks once per converter clock.
`timescale 1ns/1ps
module adcsq_core_model
    import adcsq_pkg::*;
(
    // Clock
    input wire logic clk,
    // Sequencer side
    input wire logic conv_reset,
    input wire logic launch,
    input wire logic tick,
    input wire logic power_down,
    input wire logic [2:0] chan,
    // Result
    output logic [11:0] result
);
    logic [11:0] val_reg;
    logic [4:0] cnt_reg;
    logic [1:0] hold_reg;
    logic active_reg;

    // Outside a conversion the result is not held: show the inverse
    assign result = active_reg ? val_reg : ~val_reg;

    always_ff @(posedge clk) begin
        if (conv_reset || power_down) begin
            active_reg <= 1'b0;
        end else if (launch) begin
            val_reg <= 12'hA5C ^ {4{chan}};
            cnt_reg <= 5'h00;
            hold_reg <= 2'h0;
            active_reg <= 1'b1;
        end else if (active_reg && cnt_reg != 5'h10) begin
            cnt_reg <= cnt_reg + 5'(tick);
        end else if (active_reg) begin
            // Brief hold past the last tick covers the sampling edge
            hold_reg <= hold_reg + 2'h1;
            active_reg <= (hold_reg != 2'h2);
        end
    end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the converter sequencer.
// Assumes the core model drives the result and the bench is the bus master.
`timescale 1ns/1ps
module tb
    import adcsq_pkg::*;
;
    logic clk, srst, cyc, stb, we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_i, dat_o;
    logic ack, irq, c_rst, c_launch, c_tick, c_pd, ref_sel, vref_taken;
    logic [2:0] chan;
    logic [5:0] pins, pull_off;
    logic [11:0] res;
    logic [7:0] q;
    logic irq_d;
    int n_fail, num_checks, cyc_cnt, tick_cnt, prev_t, gap_mid, launches, irq_cyc, irq_ticks;
    logic [2:0] codes [8] = '{DIV_CODE_1, DIV_CODE_2, DIV_CODE_4, DIV_CODE_8, DIV_CODE_16,
        DIV_CODE_32, 3'h3, 3'h7};
    int ratios [8] = '{1, 2, 4, 8, 16, 32, 32, 32};

    adcsq_top dut(.CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .IRQ_O(irq), .RESULT_IN(res), .CONV_RESET(c_rst), .CONV_LAUNCH(c_launch),
        .CONV_TICK(c_tick), .CONV_POWER_DOWN(c_pd), .INPUT_CHANNEL_SELECT(chan),
        .REF_SOURCE_SELECT(ref_sel), .VREF_PIN_TAKEN(vref_taken),
        .ANALOG_PIN_ENABLES(pins), .PULLUP_DISCONNECT(pull_off));
    adcsq_core_model model(.clk(clk), .conv_reset(c_rst), .launch(c_launch), .tick(c_tick),
        .power_down(c_pd), .chan(chan), .result(res));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Timing monitor, sampled mid-cycle where outputs are settled
    always @(negedge clk) begin
        if (c_launch === 1'b1) begin
            cyc_cnt = 0;
            tick_cnt = 0;
            prev_t = 0;
            launches++;
        end else cyc_cnt++;
        if (c_tick === 1'b1) begin
            tick_cnt++;
            if (tick_cnt == 8) gap_mid = cyc_cnt - prev_t;
            prev_t = cyc_cnt;
        end
        if (irq === 1'b1 && irq_d !== 1'b1) begin
            irq_cyc = cyc_cnt;
            irq_ticks = tick_cnt;
        end
        irq_d = irq;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        num_checks++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= {24'h000000, d};
        // Ack and read data are taken at the same rising edge
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk_rng("wb_ack", 0, 0, n);
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        // Return mid-cycle so callers see settled outputs
        @(negedge clk);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk8(nm, e, q);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) chk_rng("irq_wait", 0, 1999, n);
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd("ctrl_rst", ADR_CONV_CTRL, 8'h40);
        rd("cpr_rst", ADR_CLK_PWR_REF, 8'h80);
        rd("pins_rst", ADR_PIN_SELECT, 8'h00);
        wb(1'b1, ADR_CLK_PWR_REF, 8'hFF);
        rd("cpr_rd", ADR_CLK_PWR_REF, 8'hE7);
        chk8("ref_sel", 8'h01, {7'h00, ref_sel});
        chk8("vref_taken", 8'h01, {7'h00, vref_taken});
        chk8("power_down", 8'h01, {7'h00, c_pd});
        wb(1'b1, ADR_PIN_SELECT, 8'hFF);
        rd("pins_rd", ADR_PIN_SELECT, 8'h3F);
        wb(1'b1, ADR_PIN_SELECT, 8'h15);
        chk8("pins", 8'h15, {2'h0, pins});
        chk8("pull_off", 8'h15, {2'h0, pull_off});
        @(posedge clk);
        sel <= 4'h0;
        wb(1'b1, ADR_PIN_SELECT, 8'h2A);
        @(posedge clk);
        sel <= 4'h1;
        rd("pins_sel0", ADR_PIN_SELECT, 8'h15);
        wb(1'b1, 8'h1C, 8'hFF);
        rd("unmapped", 8'h1C, 8'h00);
        wb(1'b1, ADR_CLK_PWR_REF, 8'h00);
        chk8("ref_int", 8'h00, {7'h00, ref_sel});
        chk8("vref_free", 8'h00, {7'h00, vref_taken});
    endtask

    task automatic t_conv(input logic [2:0] code, input int n, input logic [2:0] ch);
        logic [11:0] e;
        e = 12'hA5C ^ {4{ch}};
        wb(1'b1, ADR_CLK_PWR_REF, {5'h00, code});
        repeat (4) @(posedge clk);
        wb(1'b1, ADR_CONV_CTRL, {5'h10, ch});
        @(negedge clk);
        chk8("conv_reset", 8'h01, {7'h00, c_rst});
        rd("busy_hold", ADR_CONV_CTRL, {5'h18, ch});
        wb(1'b1, ADR_CONV_CTRL, {5'h00, ch});
        wait_irq();
        chk_rng("conv_cycles", 16 * n, 16 * n + 2, irq_cyc);
        chk_rng("conv_ticks", 16, 18, irq_ticks);
        chk_rng("tick_gap", n, n, gap_mid);
        chk8("chan_out", {5'h00, ch}, {5'h00, chan});
        rd("busy_done", ADR_CONV_CTRL, {5'h00, ch});
        rd("res_high", ADR_RESULT_HIGH, e[11:4]);
        rd("res_low", ADR_RESULT_LOW, {e[3:0], 4'h0});
        rd("status", ADR_IRQ_STATUS, 8'h01);
        wb(1'b1, ADR_IRQ_STATUS, 8'h01);
        repeat (2) @(negedge clk);
        chk8("irq_clr", 8'h00, {7'h00, irq});
    endtask

    task automatic t_masked();
        int n;
        n = 0;
        wb(1'b1, ADR_IRQ_MASK, 8'h00);
        repeat (4) @(posedge clk);
        wb(1'b1, ADR_CONV_CTRL, 8'h80);
        wb(1'b1, ADR_CONV_CTRL, 8'h00);
        q = 8'h40;
        while (q[6] !== 1'b0 && n < 100) begin
            wb(1'b0, ADR_CONV_CTRL, 8'h00);
            n++;
        end
        chk8("busy_poll", 8'h00, q);
        chk8("irq_masked", 8'h00, {7'h00, irq});
        rd("status_m", ADR_IRQ_STATUS, 8'h01);
        wb(1'b1, ADR_IRQ_MASK, 8'h01);
        repeat (3) @(negedge clk);
        chk8("irq_unmask", 8'h01, {7'h00, irq});
        wb(1'b1, ADR_IRQ_STATUS, 8'h01);
    endtask

    task automatic t_powerdown();
        int l0;
        wb(1'b1, ADR_CLK_PWR_REF, 8'h44);
        l0 = launches;
        wb(1'b1, ADR_CONV_CTRL, 8'h82);
        wb(1'b1, ADR_CONV_CTRL, 8'h02);
        repeat (64) @(posedge clk);
        rd("busy_pd", ADR_CONV_CTRL, 8'h42);
        chk_rng("launch_pd", l0, l0, launches);
        rd("status_pd", ADR_IRQ_STATUS, 8'h00);
    endtask

    task automatic t_restart();
        wb(1'b1, ADR_CLK_PWR_REF, {5'h00, DIV_CODE_32});
        repeat (4) @(posedge clk);
        wb(1'b1, ADR_CONV_CTRL, 8'h83);
        wb(1'b1, ADR_CONV_CTRL, 8'h03);
        repeat (200) @(posedge clk);
        t_conv(DIV_CODE_32, 32, 3'h3);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        srst = 1'b1;
        {cyc, stb, we} = 3'h0;
        adr = 8'h00;
        sel = 4'h1;
        dat_i = 32'h0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_masked();
        // Codes below divide by 16 run at most 130 cycles (5200 ns) here; each run also checks result and status
        for (int i = 0; i < 8; i++) t_conv(codes[i], ratios[i], 3'(i));
        t_powerdown();
        t_restart();
        complete_run();
    end
endmodule
